/* logic/phase_shift_pkg.sv */
package phase_shift_pkg;
  localparam int unsigned CLOCK_PERIOD_NS = 40;
  localparam int unsigned NUM_OUTPUTS = 9;
  localparam int unsigned MAX_GLOBAL_DRIVERS = 4;
  localparam int unsigned SHIFT_W = 9;
  localparam int unsigned SHIFT_DENOM = 256;
  localparam logic signed [SHIFT_W-1:0] FIXED_SHIFT_MAX = 9'sd255;
  localparam logic signed [SHIFT_W-1:0] FIXED_SHIFT_MIN = -9'sd255;
  localparam int unsigned VAR_W = 12;
  localparam logic signed [VAR_W-1:0] VAR_RESET = 12'sh000;
  localparam int unsigned SETTLE_REF_CYCLES = 100;
  localparam int unsigned SETTLE_STEP_CYCLES = 3;
  localparam int unsigned SETTLE_W = 7;
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = 7'h63;
  localparam logic [1:0] STEP_TAIL_LOAD = 2'h2;
  typedef enum logic [1:0] {FB_NONE, FB_1X, FB_2X} feedback_sel_t;
  typedef enum logic [1:0] {SHIFT_OFF, SHIFT_FIXED, SHIFT_VARIABLE} shift_mode_t;

  function automatic logic signed [VAR_W-1:0] step_apply(
      input logic signed [VAR_W-1:0] cur, input logic up);
    step_apply = up ? VAR_W'(cur + 12'sh001) : VAR_W'(cur - 12'sh001);
  endfunction
endpackage

/* logic/phase_step_if.sv */
`timescale 1ns/100ps
interface phase_step_if;
  logic step_clock;
  logic step_enable;
  logic step_direction;
  logic step_done;
  logic feedback_clock_input;
  logic zero_degree_output;
  logic doubled_output;
  modport device (input step_clock, input step_enable, input step_direction,
    output step_done, input feedback_clock_input, output zero_degree_output,
    output doubled_output);
  modport fabric (output step_clock, output step_enable, output step_direction,
    input step_done, output feedback_clock_input, input zero_degree_output,
    input doubled_output);
endinterface

/* logic/clock_manager_phase.sv */
`timescale 1ns/100ps
module clock_manager_phase
  import phase_shift_pkg::*;
#(
  parameter phase_shift_pkg::feedback_sel_t FEEDBACK = phase_shift_pkg::FB_1X,
  parameter phase_shift_pkg::shift_mode_t MODE = phase_shift_pkg::SHIFT_VARIABLE,
  parameter logic signed [8:0] FIXED_SHIFT = 9'sh000,
  parameter logic INVERT_ENABLE = 1'b0,
  parameter logic INVERT_CLOCK = 1'b0,
  parameter logic INVERT_DIRECTION = 1'b0,
  parameter logic [8:0] GLOBAL_USE = 9'h003
) (
  input wire logic ref_clk,
  input wire logic nrst,
  phase_step_if.device link,
  output logic signed [phase_shift_pkg::VAR_W-1:0] shift_steps,
  output logic signed [phase_shift_pkg::SHIFT_W-1:0] fixed_shift,
  output logic feedback_locked,
  output logic [8:0] global_allow,
  output logic config_error
);
  import phase_shift_pkg::*;

  typedef struct packed {
    logic [1:0] fb_sync;
    logic fb_prev;
    logic locked;
    logic busy;
    logic [SETTLE_W-1:0] settle;
    logic settle_seen_toggle;
  } ref_state_t;

  typedef struct packed {
    logic signed [VAR_W-1:0] shift;
    logic busy;
    logic [1:0] done_sync;
    logic done_prev;
    logic [1:0] tail;
    logic done;
    logic req_toggle;
  } step_state_t;

  ref_state_t r_reg, r_next;
  step_state_t s_reg, s_next;
  logic [1:0] req_sync_reg;
  logic req_prev_reg;
  logic step_clk_int, step_en_int, step_dir_int;
  logic out_phase_reg;
  logic doubled_reg;

  // Polarity is applied before anything samples the step inputs.
  // An inverted step clock moves every step-domain edge by half a period, which
  // the fabric must allow for when it times its enable.
  assign step_clk_int = link.step_clock ^ INVERT_CLOCK;
  assign step_en_int = link.step_enable ^ INVERT_ENABLE;
  assign step_dir_int = link.step_direction ^ INVERT_DIRECTION;

  // Step domain: a request is taken only while idle, the fabric waits for done.
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.done_sync = {s_reg.done_sync[0], r_reg.settle_seen_toggle};
    if (MODE == SHIFT_VARIABLE && !s_reg.busy && step_en_int) begin
      s_next.shift = step_apply(s_reg.shift, step_dir_int);
      s_next.busy = 1'b1;
      s_next.req_toggle = ~s_reg.req_toggle;
    end
    if (s_reg.busy && s_reg.tail == 2'h0 && s_reg.done_sync[1] != s_reg.done_prev) begin
      s_next.done_prev = s_reg.done_sync[1];
      s_next.tail = STEP_TAIL_LOAD;
    end
    if (s_reg.tail != 2'h0) begin
      s_next.tail = s_reg.tail - 2'h1;
      if (s_reg.tail == 2'h1) begin
        s_next.done = 1'b1;
        s_next.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge step_clk_int or negedge nrst) begin
    if (!nrst) begin
      s_reg.shift <= VAR_RESET;
      s_reg.busy <= 1'b0;
      s_reg.done_sync <= 2'h0;
      s_reg.done_prev <= 1'b0;
      s_reg.tail <= 2'h0;
      s_reg.done <= 1'b0;
      s_reg.req_toggle <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Reference domain: settle time emulates the delay line taking effect.
  // The request crosses as a toggle, so a step clock of any rate is safe as long
  // as the fabric waits for done before the next request.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      req_sync_reg <= 2'h0;
      req_prev_reg <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[0], s_reg.req_toggle};
      req_prev_reg <= req_sync_reg[1];
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.fb_sync = {r_reg.fb_sync[0], link.feedback_clock_input};
    r_next.fb_prev = r_reg.fb_sync[1];
    if (FEEDBACK == FB_NONE) begin
      r_next.locked = 1'b1;
    end else if (r_reg.fb_sync[1] != r_reg.fb_prev) begin
      r_next.locked = 1'b1;
    end
    // The load value is one short of the settle count because the cycle that
    // reaches zero is itself part of the wait.
    if (!r_reg.busy && req_sync_reg[1] != req_prev_reg) begin
      r_next.busy = 1'b1;
      r_next.settle = SETTLE_LOAD;
    end else if (r_reg.busy) begin
      if (r_reg.settle == '0) begin
        r_next.busy = 1'b0;
        r_next.settle_seen_toggle = ~r_reg.settle_seen_toggle;
      end else begin
        r_next.settle = r_reg.settle - 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg.fb_sync <= 2'h0;
      r_reg.fb_prev <= 1'b0;
      r_reg.locked <= 1'b0;
      r_reg.busy <= 1'b0;
      r_reg.settle <= '0;
      r_reg.settle_seen_toggle <= 1'b0;
      out_phase_reg <= 1'b0;
      doubled_reg <= 1'b0;
    end else begin
      r_reg <= r_next;
      out_phase_reg <= ~out_phase_reg;
      doubled_reg <= ~doubled_reg;
    end
  end

  // Outputs are logical stand-ins; the analog delay line is not modelled.
  // Users must not read any real timing from them, only that they keep running.
  assign link.zero_degree_output = out_phase_reg;
  assign link.doubled_output = doubled_reg;
  assign link.step_done = s_reg.done;
  assign shift_steps = (MODE == SHIFT_VARIABLE) ? s_reg.shift : VAR_RESET;
  assign fixed_shift = (MODE == SHIFT_FIXED) ? FIXED_SHIFT : '0;
  assign feedback_locked = r_reg.locked;

  // Counts how many outputs ask for a global edge mux.
  function automatic logic [3:0] pop9(input logic [8:0] v);
    pop9 = 4'h0;
    for (int i = 0; i < 9; i++) begin
      pop9 = pop9 + {3'h0, v[i]};
    end
  endfunction

  logic too_many_global;
  logic fixed_out_of_range;

  // Granting an arbitrary four of too many requests would starve a clock that
  // the user believed was global, so an overcommitted set is refused whole.
  assign too_many_global = pop9(GLOBAL_USE) > 4'(MAX_GLOBAL_DRIVERS);

  // The comparison is signed; an unsigned one would reject every negative shift.
  assign fixed_out_of_range = (FIXED_SHIFT > FIXED_SHIFT_MAX)
    || (FIXED_SHIFT < FIXED_SHIFT_MIN);

  always_comb begin
    global_allow = GLOBAL_USE;
    if (too_many_global) begin
      global_allow = '0;
    end
  end

  assign config_error = too_many_global
    || (MODE == SHIFT_FIXED && fixed_out_of_range);
endmodule

/* logic/phase_step_fabric.sv */
`timescale 1ns/100ps
module phase_step_fabric
  import phase_shift_pkg::*;
#(
  parameter phase_shift_pkg::shift_mode_t MODE = phase_shift_pkg::SHIFT_VARIABLE,
  parameter phase_shift_pkg::feedback_sel_t FEEDBACK = phase_shift_pkg::FB_1X
) (
  input wire logic ref_clk,
  input wire logic nrst,
  phase_step_if.fabric link,
  input wire logic req_valid,
  input wire logic req_up,
  output logic req_ready,
  output logic step_finished
);
  import phase_shift_pkg::*;

  typedef struct packed {
    logic en;
    logic dir;
    logic wait_done;
    logic finished;
  } fab_state_t;

  fab_state_t f_reg, f_next;

  always_comb begin
    f_next = f_reg;
    f_next.en = 1'b0;
    f_next.finished = 1'b0;
    if (MODE == SHIFT_VARIABLE && !f_reg.wait_done && req_valid) begin
      f_next.en = 1'b1;
      f_next.dir = req_up;
      f_next.wait_done = 1'b1;
    end else if (f_reg.wait_done && link.step_done) begin
      f_next.wait_done = 1'b0;
      f_next.finished = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  // Fixed mode ties the step inputs low; the step clock is our own clock.
  assign link.step_clock = (MODE == SHIFT_VARIABLE) ? ref_clk : 1'b0;
  assign link.step_enable = f_reg.en;
  assign link.step_direction = f_reg.dir;
  assign link.feedback_clock_input = (FEEDBACK == FB_2X) ? link.doubled_output
    : (FEEDBACK == FB_1X) ? link.zero_degree_output : 1'b0;
  assign req_ready = (MODE == SHIFT_VARIABLE) && !f_reg.wait_done;
  assign step_finished = f_reg.finished;
endmodule

/* testbench/clock_manager_phase_asserts.sv */
`timescale 1ns/100ps
module clock_manager_phase_asserts (
  input wire logic nrst,
  input wire logic step_clock,
  input wire logic step_enable,
  input wire logic step_done,
  input wire logic zero_degree_output
);
  logic busy_reg;
  logic busy_next;
  // Tracks one request in flight, so that a second enable before done is caught.
  always_comb busy_next = step_enable ? 1'b1 : (step_done ? 1'b0 : busy_reg);
  always_ff @(posedge step_clock or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
    end
  end
  default clocking @(posedge step_clock); endclocking
  default disable iff (!nrst);
  chk_done_one_cycle: assert property (step_done |=> !step_done)
    else $error("step done held longer than one cycle");
  chk_done_not_early: assert property (step_enable |=> !step_done [*8])
    else $error("step done came too early");
  chk_done_in_time: assert property (step_enable |-> ##[8:120] step_done)
    else $error("step done missing after request");
  chk_enable_single: assert property (step_enable |=> !step_enable)
    else $error("step enable wider than one cycle");
  chk_no_enable_busy: assert property (busy_reg |-> !step_enable)
    else $error("step enable while adjustment busy");
  chk_done_has_cause: assert property (step_done |-> busy_reg)
    else $error("step done without a request");
  chk_done_then_quiet: assert property (step_done |=> !step_enable)
    else $error("step enable right after done");
  // The first edge after a release still sees the reset value, so it is skipped.
  chk_zero_toggles: assert property ($past(nrst) |-> zero_degree_output != $past(zero_degree_output))
    else $error("zero degree output stopped toggling");
endmodule

/* testbench/clock_manager_phase_shift_feedback_tb.sv */
`timescale 1ns/100ps
module clock_manager_phase_shift_feedback_tb;
  import phase_shift_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic req_up = 1'b0;
  logic req_ready, step_finished, feedback_locked, config_error, f_locked, f_err;
  logic signed [VAR_W-1:0] shift_steps;
  logic signed [VAR_W-1:0] exp_shift = 12'h000;
  logic signed [SHIFT_W-1:0] fixed_shift, f_fixed;
  logic [8:0] global_allow, f_allow;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  phase_step_if link ();
  phase_step_if fixed_link ();
  // Fixed mode leaves the step inputs unused, so they are tied low.
  assign fixed_link.step_clock = 1'b0;
  assign fixed_link.step_enable = 1'b0;
  assign fixed_link.step_direction = 1'b0;
  assign fixed_link.feedback_clock_input = 1'b0;
  clock_manager_phase i_clock_manager_phase (.ref_clk(ref_clk), .nrst(nrst), .link(link),
    .shift_steps(shift_steps), .fixed_shift(fixed_shift), .feedback_locked(feedback_locked),
    .global_allow(global_allow), .config_error(config_error));
  clock_manager_phase #(.FEEDBACK(FB_NONE), .MODE(SHIFT_FIXED), .FIXED_SHIFT(9'h101),
    .GLOBAL_USE(9'h01F)) i_clock_manager_phase_fixed (.ref_clk(ref_clk), .nrst(nrst),
    .link(fixed_link), .shift_steps(), .fixed_shift(f_fixed), .feedback_locked(f_locked),
    .global_allow(f_allow), .config_error(f_err));
  phase_step_fabric i_phase_step_fabric (.ref_clk(ref_clk), .nrst(nrst), .link(link),
    .req_valid(req_valid), .req_up(req_up), .req_ready(req_ready),
    .step_finished(step_finished));
  clock_manager_phase_asserts i_clock_manager_phase_asserts (.nrst(nrst),
    .step_clock(link.step_clock), .step_enable(link.step_enable),
    .step_done(link.step_done), .zero_degree_output(link.zero_degree_output));
  task automatic results();
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic request(input logic up);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_up <= up;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(negedge ref_clk);
    check(12'(req_ready), 12'h000);
    n = 0;
    while (step_finished !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    check(12'(step_finished), 12'h001);
    exp_shift = up ? exp_shift + 12'h001 : exp_shift - 12'h001;
  endtask
  task automatic t_reset();
    check(shift_steps, 12'h000);
    check({3'h0, global_allow}, 12'h003);
    check(12'(config_error), 12'h000);
    check(12'(feedback_locked), 12'h001);
    check({3'h0, fixed_shift}, 12'h000);
  endtask
  task automatic t_steps();
    logic [6:0] pattern;
    pattern = 7'h07;
    // Three up, then four down, so the count crosses zero into negative values.
    for (int i = 0; i < 7; i++) begin
      request(pattern[i]);
      check(shift_steps, exp_shift);
    end
  endtask
  task automatic t_mid_reset();
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_up <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check(shift_steps, 12'h000);
    @(posedge ref_clk);
    nrst <= 1'b1;
    exp_shift = 12'h000;
    repeat (4) @(negedge ref_clk);
    request(1'b1);
    check(shift_steps, exp_shift);
    check(12'(feedback_locked), 12'h001);
  endtask
  task automatic t_fixed();
    check({3'h0, f_fixed}, 12'h101);
    check({3'h0, f_allow}, 12'h000);
    check(12'(f_err), 12'h001);
    check(12'(f_locked), 12'h001);
  endtask
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    // Lock needs two synchroniser stages and an edge compare after release.
    repeat (8) @(negedge ref_clk);
    t_reset();
    t_steps();
    t_mid_reset();
    t_fixed();
    results();
  end
endmodule
